/* rtl/its_pkg.sv */

`default_nettype none

package its_pkg;

    // ------------------------------------------------------------
    // bus addressing
    // ------------------------------------------------------------
    localparam logic [6:0]  SLAVE_ADDR     = 7'h46;
    localparam logic [7:0]  REG_NB         = 8'h00;
    localparam logic [7:0]  REG_CORE       = 8'h01;
    localparam logic [7:0]  REG_PS         = 8'h02;
    localparam logic [7:0]  REG_COUNT      = 8'h03;
    localparam logic [1:0]  PTR_END        = 2'h3;

    // ------------------------------------------------------------
    // reset values and field layout
    // ------------------------------------------------------------
    localparam logic [7:0]  NB_RST         = 8'h00;
    localparam logic [7:0]  CORE_RST       = 8'h00;
    localparam logic [7:0]  PS_RST         = 8'h01;
    localparam int          OVP_BIT        = 7;
    localparam int          PG_BIT         = 6;
    localparam int          OFS_MSB        = 5;
    localparam logic signed [10:0] OFS_STEP_MV = 11'sh019;

    // ------------------------------------------------------------
    // byte framing and states
    // ------------------------------------------------------------
    localparam logic [3:0]  BIT_LAST       = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_RX     = 3'h1,
        ST_ACK    = 3'h3,
        ST_TX     = 3'h2,
        ST_MACK   = 3'h6,
        ST_IGNORE = 3'h4
    } its_state_t;

    typedef enum logic [1:0] {
        PH_CTRL = 2'h0,
        PH_REG  = 2'h1,
        PH_DATA = 2'h2
    } its_phase_t;

endpackage

`default_nettype wire

/* rtl/its_trim_slave.sv */
`timescale 1ns/100ps
`default_nettype none

module its_trim_slave
    import its_pkg::*;
(
    input  wire logic               sys_clk_i,
    input  wire logic               rstn_i,
    input  wire logic               clk_en_i,
    input  wire logic               por_ok_i,
    input  wire logic               scl_i,
    input  wire logic               sda_i,
    output logic                    sda_o,
    output logic                    sda_oe_n_o,
    output logic [7:0]              north_bridge_trim_o,
    output logic [7:0]              core_trim_o,
    output logic [7:0]              power_save_config_o,
    output logic                    nb_overvoltage_trip_o,
    output logic                    nb_power_good_output_o,
    output logic                    core_overvoltage_trip_o,
    output logic                    core_power_good_output_o,
    output logic signed [10:0]      nb_offset_mv_o,
    output logic signed [10:0]      core_offset_mv_o
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic scl_m, scl_s, scl_p;
    logic sda_m, sda_s, sda_p;
    logic por_m, por_s;

    // third stage only feeds edge detection, never the first one
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_p <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_p <= 1'b1;
            por_m <= 1'b0;
            por_s <= 1'b0;
        end else if (clk_en_i) begin
            scl_m <= scl_i;
            scl_s <= scl_m;
            scl_p <= scl_s;
            sda_m <= sda_i;
            sda_s <= sda_m;
            sda_p <= sda_s;
            por_m <= por_ok_i;
            por_s <= por_m;
        end
    end

    // scl is only ever sampled, the master owns it
    logic scl_rise, scl_fall, start_det, stop_det;
    assign scl_rise  = scl_s & ~scl_p;
    assign scl_fall  = ~scl_s & scl_p;
    assign start_det = scl_s & scl_p & sda_p & ~sda_s;
    assign stop_det  = scl_s & scl_p & ~sda_p & sda_s;

    // ------------------------------------------------------------
    // protocol engine and register file
    // ------------------------------------------------------------
    its_state_t  state_reg, state_next;
    its_phase_t  phase_reg, phase_next;
    logic [3:0]  bit_cnt_reg, bit_cnt_next;
    logic [7:0]  shreg_reg, shreg_next;
    logic [1:0]  ptr_reg, ptr_next;
    logic        rd_reg, rd_next;
    logic        pend_reg, pend_next;
    logic        oe_n_reg, oe_n_next;
    logic [7:0]  rf_reg [3];
    logic [7:0]  rf_next [3];
    logic [7:0]  rd_data;

    // past the last register a read returns zero rather than wrapping
    assign rd_data = (ptr_reg == PTR_END) ? 8'h00 : rf_reg[ptr_reg];

    always_comb begin
        state_next   = state_reg;
        phase_next   = phase_reg;
        bit_cnt_next = bit_cnt_reg;
        shreg_next   = shreg_reg;
        ptr_next     = ptr_reg;
        rd_next      = rd_reg;
        pend_next    = pend_reg;
        oe_n_next    = oe_n_reg;
        rf_next      = rf_reg;
        if (!por_s) begin
            // supply low: bus dead, contents back to power-up state
            state_next   = ST_IDLE;
            phase_next   = PH_CTRL;
            bit_cnt_next = 4'h0;
            shreg_next   = 8'h00;
            ptr_next     = 2'h0;
            rd_next      = 1'b0;
            pend_next    = 1'b0;
            oe_n_next    = 1'b1;
            rf_next[0]   = NB_RST;
            rf_next[1]   = CORE_RST;
            rf_next[2]   = PS_RST;
        end else if (stop_det) begin
            state_next = ST_IDLE;
            pend_next  = 1'b0;
            oe_n_next  = 1'b1;
        end else if (start_det) begin
            // a start without stop is tolerated as a fresh frame
            state_next   = ST_RX;
            phase_next   = PH_CTRL;
            bit_cnt_next = 4'h0;
            oe_n_next    = 1'b1;
        end else begin
            case (state_reg)
                ST_RX: begin
                    if (scl_rise) begin
                        shreg_next   = {shreg_reg[6:0], sda_s};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == BIT_LAST) begin
                        bit_cnt_next = 4'h0;
                        case (phase_reg)
                            PH_CTRL: begin
                                if (shreg_reg[7:1] == SLAVE_ADDR) begin
                                    state_next = ST_ACK;
                                    oe_n_next  = 1'b0;
                                    rd_next    = shreg_reg[0];
                                    phase_next = PH_REG;
                                end else begin
                                    state_next = ST_IDLE;
                                end
                            end
                            PH_REG: begin
                                if (shreg_reg < REG_COUNT) begin
                                    ptr_next   = shreg_reg[1:0];
                                    state_next = ST_ACK;
                                    oe_n_next  = 1'b0;
                                    phase_next = PH_DATA;
                                end else begin
                                    state_next = ST_IGNORE;
                                end
                            end
                            default: begin
                                if (ptr_reg != PTR_END) begin
                                    for (int i = 0; i < 3; i++) begin
                                        if (ptr_reg == i[1:0]) begin
                                            rf_next[i] = shreg_reg;
                                        end
                                    end
                                    ptr_next   = ptr_reg + 2'h1;
                                    pend_next  = 1'b1;
                                    state_next = ST_ACK;
                                    oe_n_next  = 1'b0;
                                end else begin
                                    state_next = ST_IGNORE;
                                end
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    // release or first data bit only after scl has gone low
                    if (scl_fall) begin
                        bit_cnt_next = 4'h0;
                        if (rd_reg) begin
                            state_next = ST_TX;
                            shreg_next = rd_data;
                            oe_n_next  = rd_data[7];
                        end else begin
                            state_next = ST_RX;
                            oe_n_next  = 1'b1;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_reg == BIT_LAST) begin
                            state_next = ST_MACK;
                            oe_n_next  = 1'b1;
                        end else begin
                            shreg_next = {shreg_reg[6:0], 1'b0};
                            oe_n_next  = shreg_reg[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        if (sda_s) begin
                            state_next = ST_IDLE;
                        end else if (ptr_reg != PTR_END) begin
                            ptr_next = ptr_reg + 2'h1;
                        end
                    end else if (scl_fall) begin
                        state_next   = ST_TX;
                        bit_cnt_next = 4'h0;
                        shreg_next   = rd_data;
                        oe_n_next    = rd_data[7];
                    end
                end
                default: begin
                    state_next = state_reg;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg   <= ST_IDLE;
            phase_reg   <= PH_CTRL;
            bit_cnt_reg <= 4'h0;
            shreg_reg   <= 8'h00;
            ptr_reg     <= 2'h0;
            rd_reg      <= 1'b0;
            pend_reg    <= 1'b0;
            oe_n_reg    <= 1'b1;
            rf_reg[0]   <= NB_RST;
            rf_reg[1]   <= CORE_RST;
            rf_reg[2]   <= PS_RST;
        end else if (clk_en_i) begin
            state_reg   <= state_next;
            phase_reg   <= phase_next;
            bit_cnt_reg <= bit_cnt_next;
            shreg_reg   <= shreg_next;
            ptr_reg     <= ptr_next;
            rd_reg      <= rd_next;
            pend_reg    <= pend_next;
            oe_n_reg    <= oe_n_next;
            rf_reg      <= rf_next;
        end
    end

    // ------------------------------------------------------------
    // applied operating values
    // ------------------------------------------------------------
    function automatic logic signed [10:0] offset_mv(input logic [5:0] code);
        logic signed [10:0] ext;
        ext = $signed({{5{code[OFS_MSB]}}, code});
        return 11'(ext * OFS_STEP_MV);
    endfunction

    logic [7:0]         app_nb_reg, app_nb_next;
    logic [7:0]         app_core_reg, app_core_next;
    logic [7:0]         app_ps_reg, app_ps_next;
    logic signed [10:0] ofs_nb_reg, ofs_nb_next;
    logic signed [10:0] ofs_core_reg, ofs_core_next;

    // staged so regulation never sees a half-written sequence
    always_comb begin
        app_nb_next   = app_nb_reg;
        app_core_next = app_core_reg;
        app_ps_next   = app_ps_reg;
        ofs_nb_next   = ofs_nb_reg;
        ofs_core_next = ofs_core_reg;
        if (!por_s) begin
            app_nb_next   = NB_RST;
            app_core_next = CORE_RST;
            app_ps_next   = PS_RST;
            ofs_nb_next   = offset_mv(NB_RST[5:0]);
            ofs_core_next = offset_mv(CORE_RST[5:0]);
        end else if (stop_det && pend_reg) begin
            app_nb_next   = rf_reg[0];
            app_core_next = rf_reg[1];
            app_ps_next   = rf_reg[2];
            ofs_nb_next   = offset_mv(rf_reg[0][OFS_MSB:0]);
            ofs_core_next = offset_mv(rf_reg[1][OFS_MSB:0]);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            app_nb_reg   <= NB_RST;
            app_core_reg <= CORE_RST;
            app_ps_reg   <= PS_RST;
            ofs_nb_reg   <= 11'sh000;
            ofs_core_reg <= 11'sh000;
        end else if (clk_en_i) begin
            app_nb_reg   <= app_nb_next;
            app_core_reg <= app_core_next;
            app_ps_reg   <= app_ps_next;
            ofs_nb_reg   <= ofs_nb_next;
            ofs_core_reg <= ofs_core_next;
        end
    end

    // open drain: the level is always low, only the enable moves
    assign sda_o                    = 1'b0;
    assign sda_oe_n_o               = oe_n_reg;
    assign north_bridge_trim_o      = app_nb_reg;
    assign core_trim_o              = app_core_reg;
    assign power_save_config_o      = app_ps_reg;
    assign nb_overvoltage_trip_o    = app_nb_reg[OVP_BIT];
    assign nb_power_good_output_o   = app_nb_reg[PG_BIT];
    assign core_overvoltage_trip_o  = app_core_reg[OVP_BIT];
    assign core_power_good_output_o = app_core_reg[PG_BIT];
    assign nb_offset_mv_o           = ofs_nb_reg;
    assign core_offset_mv_o         = ofs_core_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    logic end_byte;
    assign end_byte = clk_en_i && por_s && !start_det && !stop_det && state_reg == ST_RX
                      && scl_fall && bit_cnt_reg == BIT_LAST;

    property p_start_rx;
        clk_en_i && por_s && start_det && !stop_det |=> state_reg == ST_RX && bit_cnt_reg == 4'h0 && oe_n_reg;
    endproperty
    a_start_rx: assert property (p_start_rx) else $error("start not taken");

    property p_stop_idle;
        clk_en_i && por_s && stop_det |=> state_reg == ST_IDLE && oe_n_reg && !pend_reg;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop not taken");

    property p_ack_match;
        end_byte && phase_reg == PH_CTRL && shreg_reg[7:1] == SLAVE_ADDR |=> state_reg == ST_ACK && !oe_n_reg;
    endproperty
    a_ack_match: assert property (p_ack_match) else $error("own address not acked");

    property p_nack_foreign;
        end_byte && phase_reg == PH_CTRL && shreg_reg[7:1] != SLAVE_ADDR |=> state_reg == ST_IDLE && oe_n_reg;
    endproperty
    a_nack_foreign: assert property (p_nack_foreign) else $error("foreign address acked");

    property p_bad_reg;
        end_byte && phase_reg == PH_REG && shreg_reg >= REG_COUNT |=> state_reg == ST_IGNORE [*2] ##0 oe_n_reg;
    endproperty
    a_bad_reg: assert property (p_bad_reg) else $error("bad register address acked");

    property p_apply;
        clk_en_i && por_s && stop_det && pend_reg |=> core_trim_o == $past(rf_reg[1]) && north_bridge_trim_o == $past(rf_reg[0]);
    endproperty
    a_apply: assert property (p_apply) else $error("write not applied at stop");

    property p_sda_stable;
        clk_en_i && por_s && scl_s && scl_p && !start_det && !stop_det |=> $stable(oe_n_reg);
    endproperty
    a_sda_stable: assert property (p_sda_stable) else $error("sda moved while scl high");

    property p_por_reset;
        clk_en_i && !por_s |=> rf_reg[0] == NB_RST && rf_reg[2] == PS_RST && state_reg == ST_IDLE;
    endproperty
    a_por_reset: assert property (p_por_reset) else $error("supply loss did not reset");

    property p_tx_msb;
        clk_en_i && por_s && !stop_det && !start_det && state_reg == ST_ACK && rd_reg && scl_fall
        |=> oe_n_reg == $past(rd_data[7]);
    endproperty
    a_tx_msb: assert property (p_tx_msb) else $error("read did not start at msb");

    c_write: cover property (end_byte && phase_reg == PH_DATA ##[1:1000] stop_det && pend_reg);
    c_read: cover property (state_reg == ST_MACK && scl_rise && !sda_s);
    c_foreign: cover property (end_byte && phase_reg == PH_CTRL && shreg_reg[7:1] != SLAVE_ADDR);
    c_seq3: cover property (end_byte && phase_reg == PH_DATA && ptr_reg == 2'h2);

endmodule

`default_nettype wire

/* bench/its_bus_master.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// serial bus master model, 400 ns bit time
// ----------------------------------------
module its_bus_master (
    output logic      scl_o,
    output logic      sda_o,
    input  wire logic sda_i
);
    // idle: clock stands still high, data released to the pull-up
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // one bit: data moves only in the low phase, sampled late in the high phase
    task automatic bit_x(input logic b, output logic r);
        #100 sda_o = b;
        #100 scl_o = 1'b1;
        #150 r = sda_i;
        #50 scl_o = 1'b0;
    endtask

    // start from an idle bus; the odd 10 ns keeps every pin move off the system clock edge
    task automatic start_c;
        #110 sda_o = 1'b0;
        #100 scl_o = 1'b0;
    endtask

    // stop always precedes the next start, so no repeated start is made
    task automatic stop_c;
        #110 sda_o = 1'b0;
        #100 scl_o = 1'b1;
        #100 sda_o = 1'b1;
        #100;
    endtask

    // eight bits msb first, then the ninth pulse; release with tx all ones
    task automatic byte_x(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], rx[i]);
        end
        bit_x(mack, ack);
    endtask
endmodule

`default_nettype wire

/* bench/i2c_slave_trim_registers_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module i2c_slave_trim_registers_tb import its_pkg::*;;
    // ----------------------------------------
    // rows: reg addr, byte count, data, then expected nb/core/ps
    // ----------------------------------------
    localparam logic [63:0] ROWS [6] = '{64'h0003_C13F_5AC1_3F5A, 64'h0101_6000_00C1_605A,
        64'h0301_FF00_00C1_605A, 64'h0202_07AA_00C1_6007, 64'h0002_1F80_001F_8007,
        64'h0003_0000_0100_0001};
    logic               sys_clk, rstn, clk_en, por_ok, scl, sda_m, sda_o, sda_oe_n, sda_w;
    logic [7:0]         nb, core, ps;
    logic               nb_ovp, nb_pg, core_ovp, core_pg;
    logic signed [10:0] nb_mv, core_mv;
    logic [7:0]         exp_reg [0:2];
    int                 errors, n_checks;

    // free-running 20 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // wired-and with the pull-up: a released line reads high
    assign sda_w = sda_oe_n ? sda_m : 1'b0;

    its_trim_slave dut_u (.sys_clk_i(sys_clk), .rstn_i(rstn), .clk_en_i(clk_en), .por_ok_i(por_ok),
        .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .north_bridge_trim_o(nb),
        .core_trim_o(core), .power_save_config_o(ps), .nb_overvoltage_trip_o(nb_ovp),
        .nb_power_good_output_o(nb_pg), .core_overvoltage_trip_o(core_ovp),
        .core_power_good_output_o(core_pg), .nb_offset_mv_o(nb_mv), .core_offset_mv_o(core_mv));
    its_bus_master m_u (.scl_o(scl), .sda_o(sda_m), .sda_i(sda_w));

    // compare helpers, counted
    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t bit got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic chk_val(input logic [10:0] got, input logic [10:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t value got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // offset in mV from the signed low six bits
    function automatic logic [10:0] mv(input logic [7:0] v);
        return 11'(25 * $signed(v[5:0]));
    endfunction

    // applied outputs against the expected register file
    task automatic chk_out;
        chk_val({3'h0, nb}, {3'h0, exp_reg[0]});
        chk_val({3'h0, core}, {3'h0, exp_reg[1]});
        chk_val({3'h0, ps}, {3'h0, exp_reg[2]});
        chk_bit(nb_ovp, exp_reg[0][7]);
        chk_bit(nb_pg, exp_reg[0][6]);
        chk_bit(core_ovp, exp_reg[1][7]);
        chk_bit(core_pg, exp_reg[1][6]);
        chk_val(nb_mv, mv(exp_reg[0]));
        chk_val(core_mv, mv(exp_reg[1]));
        chk_bit(sda_o, 1'b0);
    endtask

    // write frame; acks expected only for our address and valid registers
    task automatic wr_frame(input logic [7:0] ctl, input logic [7:0] ra, input int n, input logic [23:0] dat);
        logic [7:0] rx;
        logic       ack;
        logic       ok;
        ok = (ctl[7:1] === SLAVE_ADDR) && (por_ok === 1'b1);
        m_u.start_c();
        m_u.byte_x(ctl, 1'b1, rx, ack);
        chk_bit(ack, !ok);
        if (ok) begin
            m_u.byte_x(ra, 1'b1, rx, ack);
            chk_bit(ack, ra >= REG_COUNT);
            for (int k = 0; k < n; k++) begin
                m_u.byte_x(dat[23-8*k -: 8], 1'b1, rx, ack);
                chk_bit(ack, ra + k >= REG_COUNT);
            end
        end
        m_u.stop_c();
        repeat (6) @(posedge sys_clk);
    endtask

    // set pointer, then read n bytes; master nacks the last one
    task automatic rd_frame(input logic [7:0] ra, input int n);
        logic [7:0] rx;
        logic       ack;
        wr_frame(8'h8C, ra, 0, 24'h00_0000);
        m_u.start_c();
        m_u.byte_x(8'h8D, 1'b1, rx, ack);
        chk_bit(ack, 1'b0);
        for (int k = 0; k < n; k++) begin
            m_u.byte_x(8'hFF, k == n - 1, rx, ack);
            chk_val({3'h0, rx}, {3'h0, (ra + k < REG_COUNT) ? exp_reg[ra + k] : 8'h00});
        end
        m_u.stop_c();
        repeat (6) @(posedge sys_clk);
    endtask

    // main sequence: reset, table rows, then the awkward cases
    initial begin
        logic [7:0] rx;
        logic       ack;
        errors = 0;
        n_checks = 0;
        rstn = 1'b0;
        clk_en = 1'b1;
        por_ok = 1'b1;
        exp_reg = '{8'h00, 8'h00, 8'h01};
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk_out();
        chk_bit(sda_oe_n, 1'b1);
        foreach (ROWS[i]) begin
            wr_frame(8'h8C, ROWS[i][63:56], int'(ROWS[i][55:48]), ROWS[i][47:24]);
            exp_reg = '{ROWS[i][23:16], ROWS[i][15:8], ROWS[i][7:0]};
            chk_out();
            rd_frame(8'h00, 4);
        end
        // foreign address: no ack, nothing changes
        wr_frame(8'h8E, 8'h00, 1, 24'h55_0000);
        chk_out();
        // data held back until the stop arrives
        m_u.start_c();
        m_u.byte_x(8'h8C, 1'b1, rx, ack);
        m_u.byte_x(8'h00, 1'b1, rx, ack);
        m_u.byte_x(8'h77, 1'b1, rx, ack);
        repeat (6) @(posedge sys_clk);
        chk_val({3'h0, nb}, {3'h0, exp_reg[0]});
        m_u.stop_c();
        repeat (6) @(posedge sys_clk);
        exp_reg[0] = 8'h77;
        chk_out();
        // supply loss while frozen: nothing may move until the enable returns
        clk_en <= 1'b0;
        por_ok <= 1'b0;
        repeat (6) @(posedge sys_clk);
        chk_out();
        clk_en <= 1'b1;
        repeat (6) @(posedge sys_clk);
        exp_reg = '{8'h00, 8'h00, 8'h01};
        chk_out();
        wr_frame(8'h8C, 8'h00, 1, 24'h33_0000);
        chk_out();
        por_ok <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rd_frame(8'h01, 2);
        tally_and_finish();
    end
endmodule

`default_nettype wire
